// ==== rtl/hall_defs.svh ====
// offsets, widths, shifts, reset values and timing figures of the compensation path
`ifndef HALL_DEFS_SVH
`define HALL_DEFS_SVH

`define CLK_HZ 20000000
`define OVERSAMPLE 4
`define BW_LOW_HZ 375
`define BW_MID_HZ 1500
`define BW_HIGH_HZ 3000
`define BW_SEL_LOW 2'h0
`define BW_SEL_MID 2'h1
`define BW_SEL_HIGH 2'h2

`define REG_CTRL 6'h00
`define REG_OFF_COEF 6'h04
`define REG_LIN_COLD 6'h08
`define REG_LIN_WARM 6'h0c
`define REG_SQ_COLD 6'h10
`define REG_SQ_WARM 6'h14
`define REG_GAIN 6'h18
`define REG_TRIM 6'h1c
`define REG_COARSE 6'h20
`define REG_STATUS 6'h24
`define REG_LAST_OUT 6'h28
`define REG_TEMP 6'h2c

`define GAIN_RST 12'h800
`define COARSE_RST 8'h40
`define TEMP_REF 9'h019
`define FACTORY_SHIFT 13'h0000

`define ACC_W 40
`define PROD_W 56
`define LIN_SHIFT 16
`define SQ_SHIFT 24
`define OFF_SHIFT 14
`define GAIN_SHIFT 11
`define TRIM_SHIFT 2
`define CODE_MAX 12'hfff

`define CODE_W 12
`define FIFO_DEPTH 32
`define FIFO_AW 5
`define PERIOD_W 16

`endif

// ==== rtl/hall_dsp_path.sv ====
// temperature compensation, fine gain and zero-field trim of converted samples
`include "hall_defs.svh"

// Operation
// R01: samples are imported at a rate set by the bandwidth setting
// R02: bandwidth choices 0.375, 1.5 and 3 kHz, resolution falling as bandwidth rises
// R03: offset drift corrected linearly, coefficient spans about plus/minus 122 mG per degree
// R04: offset drift correction comes after sample import
// R05: cold gain coefficients below 25 C, warm coefficients above 25 C
// R06: a drift order whose coefficient is zero leaves the sample untouched
// R07: first-order gain drift applied before second-order within the stage
// R08: compensated sample is input plus gain drift times input plus offset drift term
// R09: factory signal shift taken as zero
// R10: fine gain applied only after import and temperature compensation
// R11: output is multiplier times compensated sample plus trim; multiplier 0.6 to 1.4
// R12: zero-field trim is a fraction of the output span
// R13: programmer should change field span, not fine gain, beyond 20 percent
// R14: all processing settings held on chip and used by the path
// R15: offset drift coefficient is 8 bits, 0.954 mG per degree step
// R16: linear gain drift coefficient steps 1.53 m% per degree
// R17: each sample goes compensation, gain, trim, one output code per import
module hall_dsp_path import hall_pkg::*; #(
  parameter int IMPORT_DIV_LOW = `CLK_HZ / (`OVERSAMPLE * `BW_LOW_HZ),
  parameter int IMPORT_DIV_MID = `CLK_HZ / (`OVERSAMPLE * `BW_MID_HZ),
  parameter int IMPORT_DIV_HIGH = `CLK_HZ / (`OVERSAMPLE * `BW_HIGH_HZ)
) (
  input wire logic mclk_in, // 20 MHz clock
  input wire logic rst_n_in, // sync reset, active low
  input wire logic [5:0] avs_address_in, // byte address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_writedata_in, // write data
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall
  input wire logic [11:0] adc_sample_in, // front-end converter code
  input wire logic signed [8:0] temp_in, // ambient temperature, deg C
  output logic [11:0] output_code_out, // code to output converter
  output logic output_valid_out, // code valid
  input wire logic output_ready_in // output converter takes code
);
  cfg_s cfg_r;
  cfg_s cfg_nxt;
  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [11:0] adc_m_r, adc_s_r;
  logic signed [8:0] temp_m_r, temp_s_r;
  logic [`PERIOD_W-1:0] period_r;
  logic [`PERIOD_W-1:0] period_nxt;
  logic import_stb;
  dp_state_e state_r;
  dp_state_e state_nxt;
  logic signed [`ACC_W-1:0] acc_r;
  logic signed [`ACC_W-1:0] acc_nxt;
  logic signed [12:0] y_r;
  logic signed [12:0] y_nxt;
  logic signed [8:0] delta_r;
  logic signed [8:0] delta_nxt;
  logic signed [8:0] lin_r;
  logic signed [8:0] lin_nxt;
  logic signed [8:0] sq_r;
  logic signed [8:0] sq_nxt;
  logic [11:0] code_r;
  logic [11:0] code_nxt;
  logic [15:0] drop_r;
  logic [15:0] drop_nxt;
  logic signed [`PROD_W-1:0] prod;
  logic signed [`ACC_W-1:0] sum;
  logic warm;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [11:0] fifo_out_data;
  logic [`FIFO_AW:0] fifo_level;
  logic out_valid_r;
  logic out_valid_nxt;
  logic [11:0] out_code_r;
  logic [11:0] out_code_nxt;
  logic bus_req;

  // pins from the analog side cross via two flops
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      adc_m_r <= '0;
      adc_s_r <= '0;
      temp_m_r <= '0;
      temp_s_r <= '0;
    end else begin
      adc_m_r <= adc_sample_in;
      adc_s_r <= adc_m_r;
      temp_m_r <= temp_in;
      temp_s_r <= temp_m_r;
    end
  end

  // register file, one wait state per access
  assign bus_req = avs_read_in || avs_write_in;
  always_comb begin
    cfg_nxt = cfg_r;
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if (bus_req && wait_r) begin
      wait_nxt = 1'b0;
      rdata_nxt = '0;
      unique case (avs_address_in)
        `REG_CTRL: rdata_nxt = 32'(cfg_r.bw_sel);
        `REG_OFF_COEF: rdata_nxt = 32'($unsigned(cfg_r.off_coef));
        `REG_LIN_COLD: rdata_nxt = 32'($unsigned(cfg_r.lin_cold));
        `REG_LIN_WARM: rdata_nxt = 32'($unsigned(cfg_r.lin_warm));
        `REG_SQ_COLD: rdata_nxt = 32'($unsigned(cfg_r.sq_cold));
        `REG_SQ_WARM: rdata_nxt = 32'($unsigned(cfg_r.sq_warm));
        `REG_GAIN: rdata_nxt = 32'(cfg_r.gain);
        `REG_TRIM: rdata_nxt = 32'($unsigned(cfg_r.trim));
        `REG_COARSE: rdata_nxt = 32'(cfg_r.coarse);
        `REG_STATUS: rdata_nxt = {10'h000, fifo_level, drop_r};
        `REG_LAST_OUT: rdata_nxt = 32'(code_r);
        `REG_TEMP: rdata_nxt = 32'($unsigned(temp_s_r));
        default: rdata_nxt = '0;
      endcase
    end
    if (avs_write_in && !wait_r) begin
      unique case (avs_address_in) // R14
        `REG_CTRL: cfg_nxt.bw_sel = avs_writedata_in[1:0];
        `REG_OFF_COEF: cfg_nxt.off_coef = avs_writedata_in[7:0]; // R15
        `REG_LIN_COLD: cfg_nxt.lin_cold = avs_writedata_in[8:0]; // R16
        `REG_LIN_WARM: cfg_nxt.lin_warm = avs_writedata_in[8:0]; // R16
        `REG_SQ_COLD: cfg_nxt.sq_cold = avs_writedata_in[8:0];
        `REG_SQ_WARM: cfg_nxt.sq_warm = avs_writedata_in[8:0];
        `REG_GAIN: cfg_nxt.gain = avs_writedata_in[11:0];
        `REG_TRIM: cfg_nxt.trim = avs_writedata_in[9:0];
        `REG_COARSE: cfg_nxt.coarse = avs_writedata_in[7:0];
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cfg_r <= '0;
      cfg_r.gain <= `GAIN_RST;
      cfg_r.coarse <= `COARSE_RST;
      wait_r <= 1'b1;
      rdata_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = wait_r;

  // import period from bandwidth setting
  always_comb begin
    unique case (cfg_r.bw_sel) // R01 R02
      `BW_SEL_MID: period_nxt = `PERIOD_W'(IMPORT_DIV_MID);
      `BW_SEL_HIGH: period_nxt = `PERIOD_W'(IMPORT_DIV_HIGH);
      default: period_nxt = `PERIOD_W'(IMPORT_DIV_LOW);
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      period_r <= `PERIOD_W'(IMPORT_DIV_LOW);
    end else begin
      period_r <= period_nxt;
    end
  end

  import_rate_gen u_rate (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .period_in(period_r),
    .stb_out(import_stb)
  );

  // compensation sequence, one stage per cycle
  assign warm = temp_s_r > $signed(`TEMP_REF);
  always_comb begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    y_nxt = y_r;
    delta_nxt = delta_r;
    lin_nxt = lin_r;
    sq_nxt = sq_r;
    code_nxt = code_r;
    drop_nxt = drop_r;
    prod = '0;
    sum = '0;
    unique case (state_r)
      ST_IDLE: begin
        if (import_stb && fifo_in_ready) begin // R01 R04
          y_nxt = $signed({1'b0, adc_s_r}) - $signed(`FACTORY_SHIFT); // R09
          acc_nxt = `ACC_W'($signed({1'b0, adc_s_r}));
          delta_nxt = temp_s_r - $signed(`TEMP_REF);
          lin_nxt = warm ? cfg_r.lin_warm : cfg_r.lin_cold; // R05
          sq_nxt = warm ? cfg_r.sq_warm : cfg_r.sq_cold; // R05
          state_nxt = ST_LIN;
        end else if (import_stb && drop_r != 16'hffff) begin
          drop_nxt = drop_r + 16'h0001;
        end
      end
      ST_LIN: begin
        prod = `PROD_W'(lin_r) * `PROD_W'(delta_r) * `PROD_W'(y_r); // R08
        if (lin_r != '0) begin // R06
          acc_nxt = acc_r + `ACC_W'(prod >>> `LIN_SHIFT);
        end
        state_nxt = ST_SQ; // R07
      end
      ST_SQ: begin
        prod = `PROD_W'(sq_r) * `PROD_W'(delta_r) * `PROD_W'(delta_r) * `PROD_W'(y_r); // R08
        if (sq_r != '0) begin // R06
          acc_nxt = acc_r + `ACC_W'(prod >>> `SQ_SHIFT);
        end
        state_nxt = ST_OFF;
      end
      ST_OFF: begin
        prod = `PROD_W'(cfg_r.off_coef) * `PROD_W'($signed({1'b0, cfg_r.coarse}))
          * `PROD_W'(delta_r); // R03 R08
        acc_nxt = acc_r + `ACC_W'(prod >>> `OFF_SHIFT);
        state_nxt = ST_GAIN;
      end
      ST_GAIN: begin
        prod = `PROD_W'(acc_r) * `PROD_W'($signed({1'b0, cfg_r.gain})); // R10 R11
        acc_nxt = `ACC_W'(prod >>> `GAIN_SHIFT);
        state_nxt = ST_TRIM;
      end
      ST_TRIM: begin
        sum = acc_r + (`ACC_W'(cfg_r.trim) <<< `TRIM_SHIFT); // R11 R12
        if (sum < 0) begin
          code_nxt = '0;
        end else if (sum > `ACC_W'(`CODE_MAX)) begin
          code_nxt = `CODE_MAX;
        end else begin
          code_nxt = sum[11:0];
        end
        state_nxt = ST_PUSH;
      end
      ST_PUSH: state_nxt = ST_IDLE; // R17
      default: state_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      acc_r <= '0;
      y_r <= '0;
      delta_r <= '0;
      lin_r <= '0;
      sq_r <= '0;
      code_r <= '0;
      drop_r <= '0;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      y_r <= y_nxt;
      delta_r <= delta_nxt;
      lin_r <= lin_nxt;
      sq_r <= sq_nxt;
      code_r <= code_nxt;
      drop_r <= drop_nxt;
    end
  end

  sample_fifo #(
    .WIDTH(`CODE_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(state_r == ST_PUSH),
    .in_ready_in_out(fifo_in_ready),
    .in_data_in(code_r),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data),
    .level_out(fifo_level)
  );

  // output holding stage toward the output converter
  assign fifo_out_ready = !out_valid_r || output_ready_in;

  always_comb begin
    out_valid_nxt = out_valid_r;
    out_code_nxt = out_code_r;
    if (fifo_out_valid && fifo_out_ready) begin
      out_valid_nxt = 1'b1;
      out_code_nxt = fifo_out_data;
    end else if (output_ready_in) begin
      out_valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      out_valid_r <= 1'b0;
      out_code_r <= '0;
    end else begin
      out_valid_r <= out_valid_nxt;
      out_code_r <= out_code_nxt;
    end
  end

  assign output_code_out = out_code_r;
  assign output_valid_out = out_valid_r;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  import_start_a: assert property ( // R01
    state_r == ST_IDLE && import_stb && fifo_in_ready |=> state_r == ST_LIN)
    else $error("import not started on strobe");
  bw_period_a: assert property ( // R02
    cfg_r.bw_sel == `BW_SEL_HIGH |=> period_r == `PERIOD_W'(IMPORT_DIV_HIGH))
    else $error("high bandwidth period wrong");
  coef_select_a: assert property ( // R05
    state_r == ST_LIN |-> lin_r == (delta_r > 0 ? $past(cfg_r.lin_warm) : $past(cfg_r.lin_cold)))
    else $error("drift coefficient set not chosen by temperature");
  zero_coef_a: assert property ( // R06
    state_r == ST_LIN && lin_r == '0 |=> acc_r == $past(acc_r))
    else $error("zero coefficient changed sample");
  drift_order_a: assert property ( // R07
    state_r == ST_LIN |=> state_r == ST_SQ ##1 state_r == ST_OFF)
    else $error("drift orders out of sequence");
  gain_after_a: assert property ( // R10
    state_r == ST_OFF |=> state_r == ST_GAIN ##1 state_r == ST_TRIM)
    else $error("gain not after compensation");
  trim_code_a: assert property ( // R11
    state_r == ST_TRIM && cfg_r.trim == '0 && acc_r >= 0 && acc_r < 4096
    |=> code_r == $past(acc_r[11:0]))
    else $error("trim zero altered code");
  one_code_a: assert property ( // R17
    state_r == ST_IDLE ##1 state_r == ST_LIN |-> ##5 state_r == ST_PUSH ##1 state_r == ST_IDLE)
    else $error("sample did not yield one code");
endmodule

// ==== rtl/hall_pkg.sv ====
// shared types of the compensation path
package hall_pkg;

  typedef struct packed {
    logic [1:0] bw_sel;
    logic signed [7:0] off_coef;
    logic signed [8:0] lin_cold;
    logic signed [8:0] lin_warm;
    logic signed [8:0] sq_cold;
    logic signed [8:0] sq_warm;
    logic [11:0] gain;
    logic signed [9:0] trim;
    logic [7:0] coarse;
  } cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LIN = 3'b001,
    ST_SQ = 3'b010,
    ST_OFF = 3'b011,
    ST_GAIN = 3'b100,
    ST_TRIM = 3'b101,
    ST_PUSH = 3'b110
  } dp_state_e;

endpackage

// ==== rtl/import_rate_gen.sv ====
// import strobe generator, one pulse per programmed period
`include "hall_defs.svh"
module import_rate_gen (
  input wire logic mclk_in, // clock
  input wire logic rst_n_in, // sync reset
  input wire logic [`PERIOD_W-1:0] period_in, // cycles per import
  output logic stb_out // one-cycle import pulse
);
  logic [`PERIOD_W-1:0] cnt_r;
  logic [`PERIOD_W-1:0] cnt_nxt;
  logic stb_r;
  logic stb_nxt;

  always_comb begin
    if (cnt_r >= period_in - `PERIOD_W'(1)) begin
      cnt_nxt = '0;
      stb_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + `PERIOD_W'(1);
      stb_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
      stb_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      stb_r <= stb_nxt;
    end
  end

  assign stb_out = stb_r;

  stb_spacing_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R01
    stb_r && period_in > `PERIOD_W'(1) |=> !stb_r)
    else $error("import strobes back to back");
endmodule

// ==== rtl/sample_fifo.sv ====
// output code buffer with valid/ready on both sides
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic mclk_in, // clock
  input wire logic rst_n_in, // sync reset
  input wire logic in_valid_in, // push request
  output logic in_ready_in_out, // not full
  input wire logic [WIDTH-1:0] in_data_in, // pushed word
  output logic out_valid_out, // not empty
  input wire logic out_ready_in, // pop request
  output logic [WIDTH-1:0] out_data_out, // head word
  output logic [AW:0] level_out // words held
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] wr_nxt;
  logic [AW:0] rd_r;
  logic [AW:0] rd_nxt;
  logic push;
  logic pop;

  assign level_out = wr_r - rd_r;
  assign in_ready_in_out = level_out != (AW+1)'(DEPTH);
  assign out_valid_out = wr_r != rd_r;
  assign out_data_out = mem[rd_r[AW-1:0]];
  assign push = in_valid_in && in_ready_in_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    wr_nxt = push ? wr_r + (AW+1)'(1) : wr_r;
    rd_nxt = pop ? rd_r + (AW+1)'(1) : rd_r;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data_in;
    end
  end

  level_bound_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R17
    level_out <= (AW+1)'(DEPTH))
    else $error("fifo level beyond depth");
endmodule

// ==== tb/front_end_model.sv ====
// far side model: converter source and output converter sink
module front_end_model (
  input wire logic mclk_in, // clock
  input wire logic rst_n_in, // sync reset, active low
  input wire logic [11:0] sample_set_in, // code the converter delivers
  input wire logic signed [8:0] temp_set_in, // ambient temperature reported
  input wire logic stall_in, // hold off the output converter
  input wire logic [11:0] code_in, // output code from the path
  input wire logic valid_in, // output code valid
  output logic [11:0] adc_sample_out, // converter code
  output logic signed [8:0] temp_out, // temperature
  output logic ready_out, // sink accepts code
  output logic [15:0] taken_out, // codes accepted
  output logic [11:0] last_out // last accepted code
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    adc_sample_out = 12'h000;
    temp_out = 9'h000;
    ready_out = 1'b0;
    taken_out = 16'h0000;
    last_out = 12'h000;
  end
  always @(posedge mclk_in) begin
    adc_sample_out <= sample_set_in;
    temp_out <= temp_set_in;
    ready_out <= rst_n_in && !stall_in;
    if (!rst_n_in) begin
      taken_out <= 16'h0000;
    end else if (valid_in && ready_out) begin
      taken_out <= taken_out + 16'h0001;
      last_out <= code_in;
    end
  end
endmodule

// ==== tb/hall_dsp_compensation_path_tb.sv ====
// self-checking bench of the compensation path
`include "hall_defs.svh"
module hall_dsp_compensation_path_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import hall_pkg::*;
  typedef struct packed {
    cfg_s cfg;
    logic [11:0] smp;
    logic signed [8:0] tmp;
  } row_s;
  localparam int DIV_L = 20;
  localparam int DIV_M = 10;
  localparam int DIV_H = 8;
  int div [3] = '{DIV_L, DIV_M, DIV_H};
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic valid;
  logic ready;
  logic stall = 1'b0;
  logic [11:0] adc;
  logic [11:0] code;
  logic [11:0] last;
  logic [11:0] smp = 12'h000;
  logic [11:0] hold;
  logic signed [8:0] temp;
  logic signed [8:0] tmp = 9'h000;
  logic [15:0] taken;
  logic [15:0] d1;
  logic [31:0] q;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;
  row_s rows [9];

  hall_dsp_path #(.IMPORT_DIV_LOW(DIV_L), .IMPORT_DIV_MID(DIV_M), .IMPORT_DIV_HIGH(DIV_H))
    u_hall_dsp_path (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .adc_sample_in(adc),
    .temp_in(temp), .output_code_out(code), .output_valid_out(valid),
    .output_ready_in(ready));
  front_end_model u_front_end_model (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .sample_set_in(smp), .temp_set_in(tmp), .stall_in(stall), .code_in(code),
    .valid_in(valid), .adc_sample_out(adc), .temp_out(temp), .ready_out(ready),
    .taken_out(taken), .last_out(last));

  initial begin
    forever #25 mclk_in = ~mclk_in;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one access: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do @(posedge mclk_in); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wait_codes(input int n);
    logic [15:0] c;
    c = taken;
    do @(negedge mclk_in); while (taken < c + 16'(n));
  endtask

  function automatic logic [31:0] expect_code(input row_s r);
    longint d, y, lin, sq, acc;
    d = longint'(r.tmp) - 25;
    y = longint'(r.smp);
    lin = (d > 0) ? r.cfg.lin_warm : r.cfg.lin_cold;
    sq = (d > 0) ? r.cfg.sq_warm : r.cfg.sq_cold;
    acc = y + ((lin * d * y) >>> 16) + ((sq * d * d * y) >>> 24);
    acc = acc + ((longint'(r.cfg.off_coef) * longint'(r.cfg.coarse) * d) >>> 14);
    acc = ((acc * longint'(r.cfg.gain)) >>> 11) + longint'(r.cfg.trim) * 4;
    if (acc < 0)
      acc = 0;
    if (acc > 4095)
      acc = 4095;
    return 32'(acc);
  endfunction

  task automatic apply(input row_s r);
    bus(1'b1, `REG_CTRL, 32'(r.cfg.bw_sel));
    bus(1'b1, `REG_OFF_COEF, 32'(r.cfg.off_coef));
    bus(1'b1, `REG_LIN_COLD, 32'(r.cfg.lin_cold));
    bus(1'b1, `REG_LIN_WARM, 32'(r.cfg.lin_warm));
    bus(1'b1, `REG_SQ_COLD, 32'(r.cfg.sq_cold));
    bus(1'b1, `REG_SQ_WARM, 32'(r.cfg.sq_warm));
    bus(1'b1, `REG_GAIN, 32'(r.cfg.gain));
    bus(1'b1, `REG_TRIM, 32'(r.cfg.trim));
    bus(1'b1, `REG_COARSE, 32'(r.cfg.coarse));
    smp <= r.smp;
    tmp <= r.tmp;
    wait_codes(4);
  endtask

  initial begin
    // bw, off, lin cold/warm, sq cold/warm, gain, trim, coarse, sample, temp
    rows[0] = {2'h0,8'h00,9'h000,9'h000,9'h000,9'h000,12'h800,10'h000,8'h40,12'h400,9'h019};
    rows[1] = {2'h1,8'h00,9'h040,9'h000,9'h000,9'h000,12'h800,10'h000,8'h40,12'h800,9'h1f1};
    rows[2] = {2'h2,8'h00,9'h1ce,9'h064,9'h000,9'h000,12'h800,10'h000,8'h40,12'h300,9'h055};
    rows[3] = {2'h0,8'h00,9'h000,9'h020,9'h000,9'h032,12'h800,10'h000,8'h40,12'h500,9'h07d};
    rows[4] = {2'h1,8'hec,9'h000,9'h000,9'h000,9'h000,12'h800,10'h000,8'h80,12'h600,9'h1d8};
    rows[5] = {2'h2,8'h00,9'h000,9'h000,9'h000,9'h000,12'h4cd,10'h39c,8'h40,12'h700,9'h019};
    rows[6] = {2'h0,8'h00,9'h000,9'h000,9'h000,9'h000,12'hb33,10'h0c8,8'h40,12'hf00,9'h019};
    rows[7] = {2'h1,8'h10,9'h050,9'h050,9'h030,9'h030,12'h800,10'h000,8'h40,12'h400,9'h019};
    rows[8] = {2'h2,8'h00,9'h000,9'h000,9'h1f6,9'h000,12'h800,10'h000,8'h40,12'h800,9'h1d8};
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(negedge mclk_in);
    chk(32'(valid), 32'h0);
    chk(32'(code), 32'h0);
    chk(32'(wreq), 32'h1);
    bus(1'b0, `REG_GAIN, 32'h0);
    chk(q, 32'h800);
    bus(1'b0, `REG_COARSE, 32'h0);
    chk(q, 32'h40);
    bus(1'b0, `REG_CTRL, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 6'h30, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `REG_OFF_COEF, 32'h1ff);
    bus(1'b0, `REG_OFF_COEF, 32'h0);
    chk(q, 32'hff);
    bus(1'b1, `REG_LIN_COLD, 32'hfff);
    bus(1'b0, `REG_LIN_COLD, 32'h0);
    chk(q, 32'h1ff);
    $display("reset and register test done");
    // gains within 20 percent of nominal except the two span rows
    for (int i = 0; i < 9; i++) begin
      apply(rows[i]);
      chk(32'(last), expect_code(rows[i]));
    end
    bus(1'b0, `REG_TEMP, 32'h0);
    chk(q, 32'h1d8);
    bus(1'b0, `REG_LAST_OUT, 32'h0);
    chk(q, expect_code(rows[8]));
    $display("row test done");
    for (int b = 0; b < 3; b++) begin
      bus(1'b1, `REG_CTRL, 32'(b));
      wait_codes(2);
      t0 = cyc;
      wait_codes(1);
      chk(32'(cyc - t0), 32'(div[b]));
    end
    $display("import rate test done");
    stall <= 1'b1;
    do bus(1'b0, `REG_STATUS, 32'h0); while (q[21:16] !== 6'h20);
    d1 = q[15:0];
    hold = code;
    repeat (40) @(posedge mclk_in);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk(32'(q[15:0] > d1), 32'h1);
    chk(32'(q[21:16]), 32'h20);
    chk(32'(valid), 32'h1);
    chk(32'(code), 32'(hold));
    bus(1'b1, `REG_STATUS, 32'h0);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk(32'(q[21:16]), 32'h20);
    stall <= 1'b0;
    do bus(1'b0, `REG_STATUS, 32'h0); while (q[21:16] !== 6'h00);
    $display("buffer test done");
    rst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(negedge mclk_in);
    chk(32'(valid), 32'h0);
    bus(1'b0, `REG_GAIN, 32'h0);
    chk(q, 32'h800);
    chk(32'(code), 32'h0);
    bus(1'b0, `REG_CTRL, 32'h0);
    chk(q, 32'h0);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule
